// ### rtl/cab_counter_array.sv
// cab_counter_array: shared 16-bit counter, timebase select, byte snapshot read,
// overflow flags and interrupt gathering, reached over axi4-lite.
// assumes slow oscillator ticks and the external count input arrive as levels
// from other clocks; they are synchronised here. module event flags come in as pulses.
// What this block does
// - one shared 16-bit up-counter, read as high and low byte, feeding six modules
// - low-byte read snapshots high byte; next high-byte read returns the snapshot
// - byte reads never disturb counting; only the snapshot changes
// - timebase 000 sys/12, 001 sys/4, 010 timer 0 overflow, 100 sys, 111 reserved
// - timebase 011 counts falling edges of external count input, up to sys/2
// - 101 external osc/8, 110 real-time osc/8, both synchronised before counting
// - wrap from 0xFFFF to 0x0000 sets the counter overflow flag
// - overflow flag requests interrupt only while its enable is 1
// - flags are not cleared on vectoring; software clears them
// - idle-stop 0 keeps counting while processor idles
// - partial overflow flag set on overflow of bit 8, 9, 10 or 11
// - eight event flags: overflow, partial overflow, six module flags
// - flags set on their trigger whatever their enable
// - each flag gated by its enable, gated flags ORed into one request
// - request passes only while global and array enables are both 1
// - module 5 starts in watchdog mode; writes restricted while enabled
// - partial overflow bit position follows 2-bit cycle length select
//
// The AXI4-Lite register port and the register addresses are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
module cab_counter_array (
  input  wire logic        core_clk,
  input  wire logic        reset,
  input  wire logic        cpu_idle,
  input  wire logic        timer0_overflow,
  input  wire logic        external_count_input,
  input  wire logic        ext_osc_clk_level,
  input  wire logic        rtc_osc_clk_level,
  input  wire logic [5:0]  module_event_set,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             irq_request,
  output logic [15:0]      counter_value,
  output logic             watchdog_function
);
  ////////////////////////////////////////////////////////////////////////////
  // registers
  logic [15:0] counter_array;
  logic [7:0]  snapshot_high;
  logic [7:0]  array_mode_reg;
  logic [4:0]  control_reg;
  logic [7:0]  event_flags;
  logic [5:0]  module_irq_enable;
  logic [3:0]  div12_cnt;
  logic [1:0]  div4_cnt;
  logic [2:0]  ext_sync;
  logic [2:0]  xosc_sync;
  logic [2:0]  rtc_sync;
  logic [2:0]  xosc_div;
  logic [2:0]  rtc_div;
  logic        aw_held;
  logic        w_held;
  logic [7:0]  aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;

  cab_pkg::cab_timebase_type timebase_select;
  assign timebase_select = cab_pkg::cab_timebase_type'(
    array_mode_reg[cab_pkg::MODE_TB_LSB +: 3]);

  ////////////////////////////////////////////////////////////////////////////
  // timebase tick generation
  wire ext_fall  = ext_sync[2] & ~ext_sync[1];
  wire xosc_rise = xosc_sync[1] & ~xosc_sync[2];
  wire rtc_rise  = rtc_sync[1] & ~rtc_sync[2];
  // each /8 tick is made after the synchroniser, so the slow clock never clocks logic
  wire xosc_tick = xosc_rise & (xosc_div == 3'd7);
  wire rtc_tick  = rtc_rise & (rtc_div == 3'd7);
  wire tick_div12 = (div12_cnt == cab_pkg::DIV12_LAST);
  wire tick_div4  = (div4_cnt == cab_pkg::DIV4_LAST);

  logic raw_tick;
  always_comb begin
    case (timebase_select)
      cab_pkg::CAB_TB_DIV12: raw_tick = tick_div12;
      cab_pkg::CAB_TB_DIV4:  raw_tick = tick_div4;
      cab_pkg::CAB_TB_T0OV:  raw_tick = timer0_overflow;
      cab_pkg::CAB_TB_EXTIN: raw_tick = ext_fall;
      cab_pkg::CAB_TB_SYS:   raw_tick = 1'b1;
      cab_pkg::CAB_TB_XOSC:  raw_tick = xosc_tick;
      cab_pkg::CAB_TB_RTC:   raw_tick = rtc_tick;
      default:               raw_tick = 1'b0;
    endcase
  end

  wire idle_hold  = array_mode_reg[cab_pkg::MODE_IDLE_STP] & cpu_idle;
  wire count_tick = raw_tick & ~idle_hold;
  wire [15:0] next_counter = counter_array + 16'h0001;
  wire wrap = count_tick & (counter_array == 16'hffff);

  // partial overflow: carry out of the selected bit, cycle length 8..11
  function automatic logic low_all_ones(input logic [15:0] v, input logic [11:0] mask);
    logic [11:0] low;
    low = v[11:0] & mask;
    low_all_ones = (low == mask);
  endfunction : low_all_ones

  wire [1:0] cycle_length_select = control_reg[cab_pkg::CTL_CYCLE_LENGTH_SELECT_LSB +: 2];
  logic [11:0] cyc_mask;
  always_comb begin
    case (cycle_length_select)
      2'd0:    cyc_mask = 12'h0ff;
      2'd1:    cyc_mask = 12'h1ff;
      2'd2:    cyc_mask = 12'h3ff;
      default: cyc_mask = 12'h7ff;
    endcase
  end
  wire partial_wrap = count_tick & low_all_ones(counter_array, cyc_mask);

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      div12_cnt <= 4'h0;
      div4_cnt  <= 2'h0;
      ext_sync  <= 3'h7;
      xosc_sync <= 3'h0;
      rtc_sync  <= 3'h0;
      xosc_div  <= 3'h0;
      rtc_div   <= 3'h0;
    end else begin
      div12_cnt <= tick_div12 ? 4'h0 : div12_cnt + 4'h1;
      div4_cnt  <= div4_cnt + 2'h1;
      ext_sync  <= {ext_sync[1:0], external_count_input};
      xosc_sync <= {xosc_sync[1:0], ext_osc_clk_level};
      rtc_sync  <= {rtc_sync[1:0], rtc_osc_clk_level};
      if (xosc_rise) xosc_div <= xosc_div + 3'h1;
      if (rtc_rise) rtc_div <= rtc_div + 3'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // axi4-lite slave: one write and one read at a time
  wire wr_go = aw_held & w_held & ~s_axi_bvalid;
  wire rd_go = s_axi_arvalid & s_axi_arready;
  wire wdog_on = array_mode_reg[cab_pkg::MODE_WDOG];
  wire wr_known = (aw_addr == cab_pkg::ADDR_MODE) || (aw_addr == cab_pkg::ADDR_CONTROL)
                  || (aw_addr == cab_pkg::ADDR_FLAGS) || (aw_addr == cab_pkg::ADDR_ENABLES);
  // watchdog mode locks the mode word except for clearing the watchdog bit itself
  wire wr_mode  = wr_go & w_strb[0] & (aw_addr == cab_pkg::ADDR_MODE);
  wire wr_ctl   = wr_go & w_strb[0] & (aw_addr == cab_pkg::ADDR_CONTROL);
  wire wr_flags = wr_go & w_strb[0] & (aw_addr == cab_pkg::ADDR_FLAGS);
  wire wr_en    = wr_go & w_strb[0] & (aw_addr == cab_pkg::ADDR_ENABLES);
  wire rd_low   = rd_go & (s_axi_araddr == cab_pkg::ADDR_COUNT_LOW);

  logic [31:0] rd_word;
  logic        rd_known;
  always_comb begin
    rd_known = 1'b1;
    if (s_axi_araddr == cab_pkg::ADDR_COUNT_LOW) begin
      rd_word = {24'h00_0000, counter_array[7:0]};
    end else if (s_axi_araddr == cab_pkg::ADDR_COUNT_HIGH) begin
      rd_word = {24'h00_0000, snapshot_high};
    end else if (s_axi_araddr == cab_pkg::ADDR_MODE) begin
      rd_word = {24'h00_0000, array_mode_reg};
    end else if (s_axi_araddr == cab_pkg::ADDR_CONTROL) begin
      rd_word = {27'h000_0000, control_reg};
    end else if (s_axi_araddr == cab_pkg::ADDR_FLAGS) begin
      rd_word = {24'h00_0000, event_flags};
    end else if (s_axi_araddr == cab_pkg::ADDR_ENABLES) begin
      rd_word = {26'h000_0000, module_irq_enable};
    end else begin
      rd_word  = 32'h0000_0000;
      rd_known = 1'b0;
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_addr <= 8'h00;
      w_data  <= 32'h0000_0000;
      w_strb  <= 4'h0;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= cab_pkg::RESP_OKAY;
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= cab_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid & s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= {s_axi_awaddr[7:2], 2'b00};
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_go) begin
        aw_held <= 1'b0;
        w_held  <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_known ? cab_pkg::RESP_OKAY : cab_pkg::RESP_SLVERR;
      end
      if (s_axi_bvalid & s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
      if (rd_go) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= rd_word;
        s_axi_rresp   <= rd_known ? cab_pkg::RESP_OKAY : cab_pkg::RESP_SLVERR;
      end
      if (s_axi_rvalid & s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // counter, configuration and event flags
  wire [7:0] hw_set = {module_event_set, partial_wrap, wrap};
  // write-one-to-clear; a set in the same cycle wins
  wire [7:0] sw_clr = wr_flags ? w_data[7:0] : 8'h00;
  wire [7:0] next_flags = (event_flags & ~sw_clr) | hw_set;

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      counter_array     <= 16'h0000;
      snapshot_high     <= 8'h00;
      array_mode_reg    <= cab_pkg::MODE_RESET;
      control_reg       <= 5'h00;
      event_flags       <= 8'h00;
      module_irq_enable <= 6'h00;
    end else begin
      if (count_tick) counter_array <= next_counter;
      if (rd_low) snapshot_high <= counter_array[15:8];
      if (wr_mode & ~wdog_on) begin
        array_mode_reg <= w_data[7:0];
      end else if (wr_mode) begin
        array_mode_reg[cab_pkg::MODE_WDOG] <= w_data[cab_pkg::MODE_WDOG];
      end
      if (wr_ctl) control_reg <= w_data[4:0];
      event_flags <= next_flags;
      if (wr_en & ~wdog_on) module_irq_enable <= w_data[5:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt gathering
  wire [7:0] irq_gate = {module_irq_enable,
                         control_reg[cab_pkg::CTL_POVF_IE],
                         array_mode_reg[cab_pkg::MODE_OVF_IE]};
  wire any_gated = |(event_flags & irq_gate);
  wire next_irq = any_gated & control_reg[cab_pkg::CTL_ARRAY_IE]
                  & control_reg[cab_pkg::CTL_GLOBAL_IE];

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      irq_request       <= 1'b0;
      counter_value     <= 16'h0000;
      watchdog_function <= 1'b1;
    end else begin
      irq_request       <= next_irq;
      counter_value     <= counter_array;
      watchdog_function <= array_mode_reg[cab_pkg::MODE_WDOG];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  chk_wrap_sets_flag: assert property (@(posedge core_clk) disable iff (reset)
    wrap |=> event_flags[cab_pkg::FLG_OVF]) else $error("overflow flag not set on wrap");
  chk_count_step: assert property (@(posedge core_clk) disable iff (reset)
    count_tick |=> counter_array == $past(counter_array) + 16'h0001)
    else $error("counter did not step by one");
  chk_idle_hold: assert property (@(posedge core_clk) disable iff (reset)
    array_mode_reg[cab_pkg::MODE_IDLE_STP] & cpu_idle |=> $stable(counter_array))
    else $error("counter moved in idle stop");
  chk_snap_read: assert property (@(posedge core_clk) disable iff (reset)
    rd_low |=> snapshot_high == $past(counter_array[15:8]))
    else $error("snapshot not taken on low read");
  chk_irq_gate: assert property (@(posedge core_clk) disable iff (reset)
    !(control_reg[cab_pkg::CTL_GLOBAL_IE] & control_reg[cab_pkg::CTL_ARRAY_IE])
    |=> !irq_request) else $error("request passed while disabled");
  chk_irq_raise: assert property (@(posedge core_clk) disable iff (reset)
    event_flags[cab_pkg::FLG_OVF] & array_mode_reg[cab_pkg::MODE_OVF_IE]
    & control_reg[cab_pkg::CTL_ARRAY_IE] & control_reg[cab_pkg::CTL_GLOBAL_IE]
    |=> irq_request) else $error("enabled flag gave no request");
  chk_flag_sticky: assert property (@(posedge core_clk) disable iff (reset)
    event_flags[cab_pkg::FLG_OVF] & !wr_flags |=> event_flags[cab_pkg::FLG_OVF])
    else $error("overflow flag cleared without software");
  chk_partial_flag: assert property (@(posedge core_clk) disable iff (reset)
    partial_wrap |=> event_flags[cab_pkg::FLG_POVF]) else $error("partial flag missed");
  chk_sys_rate: assert property (@(posedge core_clk) disable iff (reset)
    timebase_select == cab_pkg::CAB_TB_SYS && !idle_hold
    |=> counter_array == $past(counter_array) + 16'h0001)
    else $error("system timebase did not tick");
endmodule : cab_counter_array
`default_nettype wire

// ### rtl/cab_pkg.sv
// cab_pkg: register map, field positions, reset values and timebase codes of the
// counter array timebase and interrupt block.
// assumes a 32-bit axi4-lite master and a 100 MHz core clock.
package cab_pkg;
  // byte addresses of the register words
  localparam logic [7:0] ADDR_COUNT_LOW  = 8'h00;
  localparam logic [7:0] ADDR_COUNT_HIGH = 8'h04;
  localparam logic [7:0] ADDR_MODE       = 8'h08;
  localparam logic [7:0] ADDR_CONTROL    = 8'h0c;
  localparam logic [7:0] ADDR_FLAGS      = 8'h10;
  localparam logic [7:0] ADDR_ENABLES    = 8'h14;
  // array_mode_reg fields
  localparam int MODE_OVF_IE   = 0;
  localparam int MODE_TB_LSB   = 1;
  localparam int MODE_WDOG     = 6;
  localparam int MODE_IDLE_STP = 7;
  localparam logic [7:0] MODE_RESET = 8'h40;
  // control word fields
  localparam int CTL_CYCLE_LENGTH_SELECT_LSB = 0;
  localparam int CTL_POVF_IE   = 2;
  localparam int CTL_ARRAY_IE  = 3;
  localparam int CTL_GLOBAL_IE = 4;
  // flags word: bit 0 overflow, bit 1 partial overflow, bits 7:2 module flags
  localparam int FLG_OVF  = 0;
  localparam int FLG_POVF = 1;
  localparam int FLG_MOD  = 2;
  localparam int NUM_MODULES = 6;
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  localparam logic [3:0] DIV12_LAST = 4'd11;
  localparam logic [1:0] DIV4_LAST  = 2'd3;
  localparam logic [1:0] DIV8_BIT   = 2'd2;

  typedef enum logic [2:0] {
    CAB_TB_DIV12 = 3'b000,
    CAB_TB_DIV4  = 3'b001,
    CAB_TB_T0OV  = 3'b010,
    CAB_TB_EXTIN = 3'b011,
    CAB_TB_SYS   = 3'b100,
    CAB_TB_XOSC  = 3'b101,
    CAB_TB_RTC   = 3'b110,
    CAB_TB_RSVD  = 3'b111
  } cab_timebase_type;

  typedef struct packed {
    logic       ovf_ie;
    logic [1:0] cycle_length_select;
    logic       povf_ie;
    logic       array_ie;
    logic       global_ie;
  } cab_config_type;
endpackage : cab_pkg

// ### tb/test_cab_counter_array.sv
// test_cab_counter_array: self-checking bench for the counter array timebase block.
// assumes cab_pkg and cab_counter_array are compiled first; the bench is the only axi master.
`timescale 1ns/1ns
`default_nettype none
module test_cab_counter_array;
  typedef struct {logic [7:0] mode; logic idle; int win; int delta;} cab_row_type;
  logic        core_clk, reset, cpu_idle, timer0_overflow, external_count_input;
  logic        ext_osc_clk_level, rtc_osc_clk_level;
  logic [5:0]  module_event_set;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rr;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic        irq_request, watchdog_function;
  logic [15:0] counter_value, c0, m;
  int          miscompares = 0, compares = 0, gen = 0, g0;
  cab_row_type rows [11] = '{
    '{8'h00, 0, 120, 10}, '{8'h02, 0, 40, 10}, '{8'h04, 0, 100, 10}, '{8'h06, 0, 100, 10},
    '{8'h08, 0, 100, 100}, '{8'h0a, 0, 1600, 10}, '{8'h0c, 0, 2400, 10}, '{8'h0e, 0, 100, 0},
    '{8'h08, 1, 100, 100}, '{8'h88, 1, 100, 0}, '{8'h88, 0, 100, 100}};
  cab_counter_array DUT (.core_clk(core_clk), .reset(reset), .cpu_idle(cpu_idle),
    .timer0_overflow(timer0_overflow), .external_count_input(external_count_input),
    .ext_osc_clk_level(ext_osc_clk_level), .rtc_osc_clk_level(rtc_osc_clk_level),
    .module_event_set(module_event_set), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .irq_request(irq_request), .counter_value(counter_value),
    .watchdog_function(watchdog_function));
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    core_clk = 0;
    forever #5 core_clk = ~core_clk;
  end
  // periodic sources so that any window of whole periods holds an exact tick count
  always @(posedge core_clk) begin
    gen <= gen + 1;
    timer0_overflow <= (gen % 10) == 0;
    external_count_input <= (gen % 10) < 5;
    ext_osc_clk_level <= (gen % 20) < 10;
    rtc_osc_clk_level <= (gen % 30) < 15;
  end
  initial begin
    repeat (95000) @(posedge core_clk);
    miscompares++;
    report_and_stop();
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic report_and_stop();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : report_and_stop
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    forever begin
      @(posedge core_clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 0;
      if (s_axi_bvalid === 1'b1) break;
      if (++n > 200) begin
        miscompares++;
        report_and_stop();
      end
    end
    // bready stays up between writes so no edge sees it dropped and raised at once
    check("write_resp", 32'(s_axi_bresp), 32'(cab_pkg::RESP_OKAY));
  endtask : axi_write
  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    forever begin
      @(posedge core_clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 0;
      if (s_axi_rvalid === 1'b1) break;
      if (++n > 200) begin
        miscompares++;
        report_and_stop();
      end
    end
    d = s_axi_rdata;
    r = s_axi_rresp;
    // rready stays up between reads for the same reason as bready
  endtask : axi_read
  task automatic wait_count(input logic [15:0] mask, input logic [15:0] val);
    int n;
    n = 0;
    while ((counter_value & mask) !== val) begin
      @(posedge core_clk);
      if (++n > 70000) begin
        miscompares++;
        report_and_stop();
      end
    end
  endtask : wait_count
  task automatic check_reg(input string name, input logic [7:0] a, input logic [7:0] exp);
    axi_read(a, rd, rr);
    check(name, 32'(rd[7:0]), 32'(exp));
  endtask : check_reg
  task automatic check_irq(input logic exp);
    repeat (4) @(posedge core_clk);
    check("irq_request", 32'(irq_request), 32'(exp));
  endtask : check_irq
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {reset, cpu_idle} = 2'b10;
    module_event_set = 6'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0000_0000_0000;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'b00000;
    s_axi_wstrb = 4'hf;
    repeat (12) @(posedge core_clk);
    check("reset_count", 32'(counter_value), 32'h0000_0000);
    check("reset_wdog", 32'(watchdog_function), 32'h0000_0001);
    reset <= 0;
    @(posedge core_clk);
    check_reg("mode_reset", cab_pkg::ADDR_MODE, cab_pkg::MODE_RESET);
    axi_read(8'h20, rd, rr);
    check("unmapped_resp", 32'(rr), 32'(cab_pkg::RESP_SLVERR));
    // watchdog mode locks the enables word and every mode bit but its own
    axi_write(cab_pkg::ADDR_ENABLES, 32'h0000_003f);
    check_reg("enables_locked", cab_pkg::ADDR_ENABLES, 8'h00);
    axi_write(cab_pkg::ADDR_MODE, 32'h0000_004b);
    check_reg("mode_locked", cab_pkg::ADDR_MODE, 8'h40);
    axi_write(cab_pkg::ADDR_MODE, 32'h0000_0000);
    // the pin copy of the mode bit lands one edge after the response
    @(posedge core_clk);
    check("wdog_off", 32'(watchdog_function), 32'h0000_0000);
    axi_write(cab_pkg::ADDR_ENABLES, 32'h0000_003f);
    check_reg("enables_open", cab_pkg::ADDR_ENABLES, 8'h3f);
    axi_write(cab_pkg::ADDR_ENABLES, 32'h0000_0000);
    foreach (rows[i]) begin
      axi_write(cab_pkg::ADDR_MODE, {24'h00_0000, rows[i].mode});
      cpu_idle <= rows[i].idle;
      repeat (40) @(posedge core_clk);
      c0 = counter_value;
      repeat (rows[i].win) @(posedge core_clk);
      check("count_delta", 32'(16'(counter_value - c0)), rows[i].delta);
    end
    // snapshot coherence, and reads leave the system-clock count exact
    axi_write(cab_pkg::ADDR_MODE, 32'h0000_0008);
    c0 = counter_value;
    g0 = gen;
    axi_read(cab_pkg::ADDR_COUNT_LOW, rd, rr);
    m = counter_value;
    m[7:0] = m[7:0] - rd[7:0];
    repeat (300) @(posedge core_clk);
    axi_read(cab_pkg::ADDR_COUNT_HIGH, rd, rr);
    check("snap_high", 32'(rd[7:0] === counter_value[15:8]), 32'h0000_0000);
    check("snap_coherent", 32'({m[15:8] - rd[7:0], m[7:0]} < 16'h0004), 1);
    check("read_no_disturb", 32'(16'(counter_value - c0)), 32'(16'(gen - g0)));
    // module flags set with enables off, then gated through module 5's enable alone (flag bit 7)
    axi_write(cab_pkg::ADDR_MODE, 32'h0000_000e);
    axi_write(cab_pkg::ADDR_CONTROL, 32'h0000_0018);
    axi_write(cab_pkg::ADDR_FLAGS, 32'h0000_00ff);
    check_reg("flags_clear", cab_pkg::ADDR_FLAGS, 8'h00);
    module_event_set <= 6'h3f;
    @(posedge core_clk);
    module_event_set <= 6'h00;
    check_reg("module_flags", cab_pkg::ADDR_FLAGS, 8'hfc);
    check_irq(0);
    axi_write(cab_pkg::ADDR_ENABLES, 32'h0000_0020);
    check_irq(1);
    axi_write(cab_pkg::ADDR_FLAGS, 32'h0000_0080);
    check_irq(0);
    axi_write(cab_pkg::ADDR_ENABLES, 32'h0000_0000);
    axi_write(cab_pkg::ADDR_MODE, 32'h0000_0008);
    for (int c = 0; c < 4; c++) begin
      m = 16'((32'd1 << (8 + c)) - 1);
      axi_write(cab_pkg::ADDR_CONTROL, 32'(8'h18 | c));
      wait_count(m, 16'h0010);
      axi_write(cab_pkg::ADDR_FLAGS, 32'h0000_00ff);
      wait_count(m, m - 16'h0010);
      axi_read(cab_pkg::ADDR_FLAGS, rd, rr);
      check("partial_early", 32'(rd[cab_pkg::FLG_POVF]), 0);
      wait_count(m, 16'h0010);
      axi_read(cab_pkg::ADDR_FLAGS, rd, rr);
      check("partial_set", 32'(rd[cab_pkg::FLG_POVF]), 1);
    end
    // 16-bit wrap, then every gate of the overflow request
    wait_count(16'hffff, 16'hffff);
    repeat (5) @(posedge core_clk);
    axi_read(cab_pkg::ADDR_FLAGS, rd, rr);
    check("overflow_flag", 32'(rd[cab_pkg::FLG_OVF]), 1);
    check_irq(0);
    axi_write(cab_pkg::ADDR_MODE, 32'h0000_0009);
    check_irq(1);
    axi_write(cab_pkg::ADDR_CONTROL, 32'h0000_0008);
    check_irq(0);
    axi_write(cab_pkg::ADDR_CONTROL, 32'h0000_0010);
    check_irq(0);
    axi_write(cab_pkg::ADDR_CONTROL, 32'h0000_0018);
    check_irq(1);
    axi_read(cab_pkg::ADDR_FLAGS, rd, rr);
    check("overflow_held", 32'(rd[cab_pkg::FLG_OVF]), 1);
    axi_write(cab_pkg::ADDR_FLAGS, 32'h0000_0001);
    check_irq(0);
    // second reset in mid-run
    reset <= 1;
    repeat (3) @(posedge core_clk);
    check("rerun_count", 32'(counter_value), 32'h0000_0000);
    check("rerun_wdog", 32'(watchdog_function), 32'h0000_0001);
    check("rerun_irq", 32'(irq_request), 32'h0000_0000);
    report_and_stop();
  end
endmodule : test_cab_counter_array
`default_nettype wire
